//--- rtl/txl_cfg.svh
// constants for the transmit list chain engine
`ifndef TXL_CFG_SVH
`define TXL_CFG_SVH
`define CMD_TRANSMIT 16'h0004
`define OFF_LINK 8'h00
`define OFF_LIST_COMMAND_STATUS_WORD 8'h04
`define OFF_FSIZE 8'h06
`define OFF_SEG0 8'h08
`define SEG_STRIDE 8'h06
`define LIST_COMMAND_STATUS_WORD_VALID 15
`define LIST_COMMAND_STATUS_WORD_FRAME_INT 11
`define LIST_COMMAND_STATUS_WORD_FRAME_START 13
`define LIST_COMMAND_STATUS_WORD_DONE 16'h8000
`define LIST_COMMAND_STATUS_WORD_ERR 16'h4000
`define SEG_MAX 2'h3
`define CNT_MORE 15
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_CMD 4'h2
`define REG_ADDR_HI 4'h3
`define REG_ADDR_LO 4'h4
`define REG_IRQ 4'h5
`define REG_DONE 4'h6
`define IRQ_ADAPTER 0
`define IRQ_TX_VALID 7
`define CTRL_OPEN 0
`define CTRL_HALT 1
`define ST_BUSY 0
`define ST_REJECT 1
`define ST_TX_INT 2
`define ST_LIST_ERR 3
`define ST_WAIT_VALID 4
`define ST_COMPLETE 5
`endif

//--- rtl/txl_pkg.sv
// types for the transmit list chain engine
package txl_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_LINK_HI = 4'b0001,
    S_LINK_LO = 4'b0010,
    S_LIST_COMMAND_STATUS_WORD = 4'b0011,
    S_FSIZE = 4'b0100,
    S_CNT = 4'b0101,
    S_ADR_HI = 4'b0110,
    S_ADR_LO = 4'b0111,
    S_DATA = 4'b1000,
    S_WAIT_TX = 4'b1001,
    S_STATUS = 4'b1010,
    S_VALID_WAIT = 4'b1011,
    S_RELINK = 4'b1100
  } eng_state_e;
endpackage : txl_pkg

//--- rtl/skid_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module skid_buf #(
  parameter int WIDTH = 9
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rp_r];
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else if (ce)
    begin
      if (push)
      begin
        mem_r[wp_r] <= in_data;
        wp_r <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : skid_buf
`default_nettype wire

//--- rtl/seg_mover.sv
// byte mover for one gather segment, any byte alignment
`timescale 1ns/1ps
`default_nettype none
module seg_mover (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [23:0] seg_addr,
  input wire logic [15:0] seg_count,
  output logic busy,
  output logic rd_req,
  output logic [23:0] rd_addr,
  input wire logic rd_ack,
  input wire logic [7:0] rd_byte,
  output logic [7:0] out_byte,
  output logic out_valid,
  input wire logic out_ready
);
  logic [23:0] addr_r;
  logic [15:0] left_r;
  logic pend_r;
  logic [7:0] byte_r;
  logic have_r;
  assign busy = (left_r != 16'h0) || have_r || pend_r;
  assign rd_req = pend_r;
  assign rd_addr = addr_r;
  assign out_byte = byte_r;
  assign out_valid = have_r;
  wire issue = (left_r != 16'h0) && !pend_r && !have_r;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      addr_r <= 24'h0;
      left_r <= 16'h0;
      pend_r <= 1'b0;
      have_r <= 1'b0;
      byte_r <= 8'h0;
    end
    else if (ce)
    begin
      if (start)
      begin
        addr_r <= seg_addr;
        left_r <= seg_count;
      end
      else if (issue)
        pend_r <= 1'b1;
      else if (pend_r && rd_ack)
      begin
        pend_r <= 1'b0;
        have_r <= 1'b1;
        byte_r <= rd_byte;
        addr_r <= addr_r + 24'h1;
        left_r <= left_r - 16'h1;
      end
      else if (have_r && out_ready)
        have_r <= 1'b0;
    end
  end
endmodule : seg_mover
`default_nettype wire

//--- rtl/tx_list_engine.sv
// transmit list chain engine: command intake, list walk, gather DMA, status write-back
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "txl_cfg.svh"
module tx_list_engine
  import txl_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic mem_rd_req,
  output logic [23:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [15:0] mem_rd_data,
  output logic mem_wr_req,
  output logic [23:0] mem_wr_addr,
  output logic [15:0] mem_wr_data,
  input wire logic mem_wr_ack,
  output logic [7:0] tx_byte,
  output logic tx_last,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_frame_sent
);
  eng_state_e st_r, st_nxt;
  logic [15:0] ctrl_r, status_r, cmd_r, ahi_r, done_r;
  logic [23:0] list_r, link_r;
  logic [15:0] link_hi_r, list_command_status_word_r, cnt_r, left_r, fs_list_command_status_word_r;
  logic [23:0] fs_list_r;
  logic [1:0] seg_r;
  logic [23:0] seg_addr_r;
  logic rd_pend_r, wr_pend_r, mv_start_r, frame_open_r, tx_pending_r;
  logic [15:0] rdata_nxt;
  logic [7:0] tx_byte_r;
  logic tx_last_r, tx_valid_r;
  // byte offsets inside the current list
  function automatic logic [23:0] fld(input logic [23:0] base, input logic [7:0] off);
    fld = base + {16'h0, off};
  endfunction : fld
  wire [7:0] seg_off = `OFF_SEG0 + (seg_r * `SEG_STRIDE);
  wire rd_done = rd_pend_r && mem_rd_ack;
  wire wr_done = wr_pend_r && mem_wr_ack;
  wire is_last = link_r[0];
  wire is_fs = list_command_status_word_r[`LIST_COMMAND_STATUS_WORD_FRAME_START];
  // top bit of a count word asks for another segment; the rest is the byte count
  wire seg_end = !cnt_r[`CNT_MORE] || (seg_r == `SEG_MAX - 2'h1);
  wire [15:0] seg_bytes = {1'b0, cnt_r[`CNT_MORE-1:0]};
  // a frame that closes inside the chain gets its status before the next list
  wire frame_done = frame_open_r && (left_r == 16'h0);
  wire busy = (st_r != S_IDLE);
  wire go_cmd = reg_wr && (reg_addr == `REG_ADDR_LO);
  wire go_ok = go_cmd && ctrl_r[`CTRL_OPEN] && !busy && !reg_wdata[0] && (cmd_r == `CMD_TRANSMIT);
  wire go_bad = go_cmd && !go_ok;
  wire irq_wr = reg_wr && (reg_addr == `REG_IRQ);
  wire tx_valid_irq = irq_wr && reg_wdata[`IRQ_ADAPTER] && reg_wdata[`IRQ_TX_VALID];
  wire halt = ctrl_r[`CTRL_HALT] && busy;
  // mover and buffer
  logic mv_busy, mv_req, mv_valid, mv_ready, bf_valid, bf_ready;
  logic [23:0] mv_addr;
  logic [7:0] mv_byte;
  logic [8:0] bf_data;
  wire mv_ack = mv_req && mem_rd_ack && !rd_pend_r;
  wire last_byte = (left_r == 16'h1);
  wire take = mv_valid && mv_ready;
  seg_mover u_mover (
    .clock(clock),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(mv_start_r),
    .seg_addr(seg_addr_r),
    .seg_count(seg_bytes),
    .busy(mv_busy),
    .rd_req(mv_req),
    .rd_addr(mv_addr),
    .rd_ack(mv_ack),
    .rd_byte(mv_addr[0] ? mem_rd_data[7:0] : mem_rd_data[15:8]),
    .out_byte(mv_byte),
    .out_valid(mv_valid),
    .out_ready(mv_ready)
  );
  skid_buf #(.WIDTH(9)) u_buf (
    .clock(clock),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_data({last_byte, mv_byte}),
    .in_valid(mv_valid),
    .in_ready(mv_ready),
    .out_data(bf_data),
    .out_valid(bf_valid),
    .out_ready(bf_ready)
  );
  assign bf_ready = !tx_valid_r || tx_ready;
  // field fetch address, in list order
  wire [23:0] fetch_addr =
    (st_r == S_LINK_HI) ? fld(list_r, `OFF_LINK) :
    (st_r == S_LINK_LO) ? fld(list_r, `OFF_LINK + 8'h2) :
    (st_r == S_RELINK) ? fld(list_r, `OFF_LINK + 8'h2) :
    (st_r == S_LIST_COMMAND_STATUS_WORD) ? fld(list_r, `OFF_LIST_COMMAND_STATUS_WORD) :
    (st_r == S_FSIZE) ? fld(list_r, `OFF_FSIZE) :
    (st_r == S_CNT) ? fld(list_r, seg_off) :
    (st_r == S_ADR_HI) ? fld(list_r, seg_off + 8'h2) : fld(list_r, seg_off + 8'h4);
  // a zero size in a frame-start list ends the command at once
  wire list_err = (st_r == S_FSIZE) && rd_done && is_fs && (mem_rd_data == 16'h0);
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: if (go_ok) st_nxt = S_LINK_HI;
      S_LINK_HI: if (rd_done) st_nxt = S_LINK_LO;
      S_LINK_LO: if (rd_done) st_nxt = S_LIST_COMMAND_STATUS_WORD;
      S_LIST_COMMAND_STATUS_WORD: if (rd_done) st_nxt = (mem_rd_data[`LIST_COMMAND_STATUS_WORD_FRAME_START] && !mem_rd_data[`LIST_COMMAND_STATUS_WORD_VALID]) ? S_VALID_WAIT : S_FSIZE;
      S_VALID_WAIT: if (tx_valid_irq) st_nxt = S_LIST_COMMAND_STATUS_WORD;
      S_FSIZE: if (rd_done) st_nxt = S_CNT;
      S_CNT: if (rd_done) st_nxt = S_ADR_HI;
      S_ADR_HI: if (rd_done) st_nxt = S_ADR_LO;
      S_ADR_LO: if (rd_done) st_nxt = S_DATA;
      S_DATA:
        if (!mv_start_r && !mv_busy)
          st_nxt = !seg_end ? S_CNT : ((is_last || frame_done) ? S_WAIT_TX : S_LINK_HI);
      S_WAIT_TX: if (!tx_pending_r) st_nxt = S_STATUS;
      S_STATUS: if (wr_done) st_nxt = is_last ? S_RELINK : S_LINK_HI;
      S_RELINK: if (rd_done) st_nxt = mem_rd_data[0] ? S_IDLE : S_LINK_HI;
      default: st_nxt = S_IDLE;
    endcase
    if (list_err) st_nxt = S_IDLE;
    if (halt) st_nxt = S_IDLE;
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_r <= S_IDLE;
      ctrl_r <= 16'h0;
      cmd_r <= 16'h0;
      ahi_r <= 16'h0;
      status_r <= 16'h0;
      done_r <= 16'h0;
      list_r <= 24'h0;
      link_r <= 24'h0;
      link_hi_r <= 16'h0;
      list_command_status_word_r <= 16'h0;
      cnt_r <= 16'h0;
      left_r <= 16'h0;
      fs_list_command_status_word_r <= 16'h0;
      fs_list_r <= 24'h0;
      seg_r <= 2'h0;
      seg_addr_r <= 24'h0;
      rd_pend_r <= 1'b0;
      wr_pend_r <= 1'b0;
      mv_start_r <= 1'b0;
      frame_open_r <= 1'b0;
      tx_pending_r <= 1'b0;
      reg_rdata <= 16'h0;
      tx_byte_r <= 8'h0;
      tx_last_r <= 1'b0;
      tx_valid_r <= 1'b0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
      reg_rdata <= reg_rd ? rdata_nxt : 16'h0;
      mv_start_r <= 1'b0;
      if (reg_wr && reg_addr == `REG_CTRL) ctrl_r <= reg_wdata;
      if (reg_wr && reg_addr == `REG_CMD) cmd_r <= reg_wdata;
      if (reg_wr && reg_addr == `REG_ADDR_HI) ahi_r <= reg_wdata;
      // a status read clears sticky event bits; a same-cycle event wins
      if (reg_rd && reg_addr == `REG_STATUS) status_r[`ST_LIST_ERR:`ST_REJECT] <= 3'h0;
      if (go_ok)
      begin
        list_r <= {ahi_r[7:0], reg_wdata};
        status_r[`ST_BUSY] <= 1'b1;
        status_r[`ST_COMPLETE] <= 1'b0;
      end
      if (go_bad) status_r[`ST_REJECT] <= 1'b1;
      status_r[`ST_WAIT_VALID] <= (st_nxt == S_VALID_WAIT);
      // host reads are single outstanding; strobe stays up into the next field fetch and drops on ack only when no fetch follows
      rd_pend_r <= (st_nxt inside {S_LINK_HI, S_LINK_LO, S_LIST_COMMAND_STATUS_WORD, S_FSIZE, S_CNT, S_ADR_HI, S_ADR_LO, S_RELINK})
                   && !(rd_done && st_nxt == st_r) ? 1'b1 : 1'b0;
      if (rd_done)
      begin
        case (st_r)
          S_LINK_HI: link_hi_r <= mem_rd_data;
          S_LINK_LO: link_r <= {link_hi_r[7:0], mem_rd_data};
          S_LIST_COMMAND_STATUS_WORD: list_command_status_word_r <= mem_rd_data;
          S_FSIZE:
          begin
            seg_r <= 2'h0;
            if (is_fs)
            begin
              left_r <= mem_rd_data;
              fs_list_r <= list_r;
              fs_list_command_status_word_r <= list_command_status_word_r;
              frame_open_r <= 1'b1;
            end
          end
          S_CNT: cnt_r <= mem_rd_data;
          S_ADR_HI: seg_addr_r[23:16] <= mem_rd_data[7:0];
          S_ADR_LO:
          begin
            seg_addr_r[15:0] <= mem_rd_data;
            mv_start_r <= 1'b1;
          end
          default: link_r <= link_r;
        endcase
      end
      if (st_r == S_RELINK && rd_done) link_r[15:0] <= mem_rd_data;
      if (st_r == S_DATA && st_nxt != S_DATA)
      begin
        seg_r <= seg_r + 2'h1;
        if (st_nxt == S_LINK_HI) list_r <= {link_r[23:1], 1'b0};
        if (st_nxt == S_WAIT_TX) tx_pending_r <= 1'b1;
      end
      if (take) left_r <= left_r - 16'h1;
      if (tx_frame_sent) tx_pending_r <= 1'b0;
      if (st_r == S_STATUS && !wr_pend_r && !wr_done) wr_pend_r <= 1'b1;
      if (wr_done)
      begin
        wr_pend_r <= 1'b0;
        frame_open_r <= 1'b0;
        done_r <= fs_list_command_status_word_r | `LIST_COMMAND_STATUS_WORD_DONE;
        if (fs_list_command_status_word_r[`LIST_COMMAND_STATUS_WORD_FRAME_INT]) status_r[`ST_TX_INT] <= 1'b1;
        if (!is_last) list_r <= {link_r[23:1], 1'b0};
      end
      if (st_r == S_RELINK && rd_done)
      begin
        if (mem_rd_data[0])
        begin
          status_r[`ST_TX_INT] <= 1'b1;
          status_r[`ST_COMPLETE] <= 1'b1;
          status_r[`ST_BUSY] <= 1'b0;
        end
        else
          list_r <= {link_r[23:16], mem_rd_data[15:1], 1'b0};
      end
      if (list_err)
      begin
        status_r[`ST_LIST_ERR] <= 1'b1;
        status_r[`ST_TX_INT] <= 1'b1;
        status_r[`ST_BUSY] <= 1'b0;
      end
      if (halt)
      begin
        status_r[`ST_TX_INT] <= 1'b1;
        status_r[`ST_BUSY] <= 1'b0;
        ctrl_r[`CTRL_HALT] <= 1'b0;
      end
      if (bf_ready)
      begin
        tx_valid_r <= bf_valid;
        tx_byte_r <= bf_data[7:0];
        tx_last_r <= bf_data[8];
      end
    end
  end
  always_comb
  begin
    case (reg_addr)
      `REG_CTRL: rdata_nxt = ctrl_r;
      `REG_STATUS: rdata_nxt = status_r;
      `REG_CMD: rdata_nxt = cmd_r;
      `REG_ADDR_HI: rdata_nxt = ahi_r;
      `REG_ADDR_LO: rdata_nxt = list_r[15:0];
      `REG_DONE: rdata_nxt = done_r;
      default: rdata_nxt = 16'h0;
    endcase
  end
  // status write touches only the frame-start list's status word
  assign mem_wr_req = wr_pend_r;
  assign mem_wr_addr = fld(fs_list_r, `OFF_LIST_COMMAND_STATUS_WORD);
  assign mem_wr_data = fs_list_command_status_word_r | `LIST_COMMAND_STATUS_WORD_DONE;
  assign mem_rd_req = rd_pend_r || mv_req;
  assign mem_rd_addr = rd_pend_r ? fetch_addr : {mv_addr[23:1], 1'b0};
  assign tx_byte = tx_byte_r;
  assign tx_last = tx_last_r;
  assign tx_valid = tx_valid_r;
endmodule : tx_list_engine
`default_nettype wire

//--- tb/txl_properties.sv
// concurrent checks on the list engine ports
`timescale 1ns/1ps
`default_nettype none
module txl_properties (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic mem_rd_req,
  input wire logic [23:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic mem_wr_req,
  input wire logic [23:0] mem_wr_addr,
  input wire logic [15:0] mem_wr_data,
  input wire logic mem_wr_ack,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  input wire logic tx_valid,
  input wire logic tx_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_rd_hold: assert property (mem_rd_req && !mem_rd_ack |=>
    mem_rd_req && $stable(mem_rd_addr)) else $error("read request dropped before ack");
  a_wr_hold: assert property (mem_wr_req && !mem_wr_ack |=>
    mem_wr_req && $stable({mem_wr_addr, mem_wr_data})) else $error("write request dropped before ack");
  a_rd_even: assert property (mem_rd_req |-> !mem_rd_addr[0])
    else $error("odd word read address");
  a_one_req: assert property (!(mem_rd_req && mem_wr_req))
    else $error("read and write requested together");
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable({tx_last, tx_byte})) else $error("stream word lost in stall");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_wr_done: assert property (mem_wr_req |-> mem_wr_data[15])
    else $error("status written without done bit");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
    !mem_rd_req && !mem_wr_req && !tx_valid) else $error("request active after reset");
  c_write_back: cover property (mem_wr_req && mem_wr_ack);
  c_frame_end: cover property (tx_valid && tx_ready && tx_last);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule : txl_properties
bind tx_list_engine txl_properties txl_properties_inst (.*);
`default_nettype wire

//--- tb/host_mem_model.sv
// host memory and ring side seen by the list engine
`timescale 1ns/1ps
`default_nettype none
module host_mem_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [1:0] lat,
  input wire logic mem_rd_req,
  input wire logic [23:0] mem_rd_addr,
  output logic mem_rd_ack,
  output logic [15:0] mem_rd_data,
  input wire logic mem_wr_req,
  input wire logic [23:0] mem_wr_addr,
  input wire logic [15:0] mem_wr_data,
  output logic mem_wr_ack,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_last,
  output logic tx_frame_sent
);
  logic [7:0] mem [0:4095];
  logic [1:0] wait_r = 2'h0;
  logic [3:0] sent_r = 4'h0;
  logic [15:0] word_r = 16'h0000;
  wire [11:0] ra = mem_rd_addr[11:0];
  wire [11:0] wa = mem_wr_addr[11:0];
  initial
  begin
    mem_rd_ack = 1'b0;
    mem_wr_ack = 1'b0;
  end
  // released data lines show the inverse of the last word
  assign mem_rd_data = mem_rd_ack ? word_r : ~word_r;
  assign tx_frame_sent = (sent_r == 4'h1);
  always @(posedge clock)
  begin
    mem_rd_ack <= 1'b0;
    mem_wr_ack <= 1'b0;
    if (sys_rst)
      wait_r <= 2'h0;
    else if ((mem_rd_req || mem_wr_req) && !mem_rd_ack && !mem_wr_ack)
    begin
      wait_r <= wait_r + 2'h1;
      if (wait_r >= lat)
      begin
        wait_r <= 2'h0;
        if (mem_rd_req)
        begin
          word_r <= {mem[ra], mem[ra + 12'h1]};
          mem_rd_ack <= 1'b1;
        end
        else
        begin
          {mem[wa], mem[wa + 12'h1]} <= mem_wr_data;
          mem_wr_ack <= 1'b1;
        end
      end
    end
  end
  // ring reports the frame gone some cycles after its last byte
  always @(posedge clock)
    if (sys_rst)
      sent_r <= 4'h0;
    else if (tx_valid && tx_ready && tx_last)
      sent_r <= 4'h8;
    else if (sent_r != 4'h0)
      sent_r <= sent_r - 4'h1;
endmodule : host_mem_model
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the transmit list chain engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0, sys_rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, tx_ready = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, mem_rd_data, mem_wr_data, st;
  logic mem_rd_req, mem_rd_ack, mem_wr_req, mem_wr_ack, tx_last, tx_valid, tx_frame_sent, any_int;
  logic [23:0] mem_rd_addr, mem_wr_addr;
  logic [7:0] tx_byte;
  logic [1:0] lat = 2'h0;
  logic [31:0] seed = 32'd77586, rdy_s = 32'd77586;
  logic [8:0] got_q[$], exp_q[$];
  logic [15:0] wa_q[$];
  int errors = 0, samples_checked = 0;
  int cnt[6];
  always #20 clock = ~clock;
  tx_list_engine tx_list_engine_inst (.*);
  host_mem_model host_mem_model_inst (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic end_of_test;
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_byte(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t stream %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask : rd
  task automatic launch(input logic [23:0] a);
    wr(4'h2, 16'h0004);
    wr(4'h3, {8'h00, a[23:16]});
    wr(4'h4, a[15:0]);
  endtask : launch
  task automatic put16(input int a, input logic [15:0] d);
    host_mem_model_inst.mem[a] = d[15:8];
    host_mem_model_inst.mem[a + 1] = d[7:0];
  endtask : put16
  // one list: link, status word, size, then n gather segments
  task automatic mk_list(input int b, input int link, input logic [15:0] cs, input int fsz, input int k,
                         input int n, input bit endf);
    int da;
    put16(b, 16'h0000);
    put16(b + 2, link[15:0]);
    put16(b + 4, cs);
    put16(b + 6, fsz[15:0]);
    for (int i = 0; i < n; i++)
    begin
      seed = lfsr(seed);
      da = 'h400 + (k + i) * 32 + seed[0];
      put16(b + 8 + 6 * i, {(i < n - 1) || (i == 2), 15'(cnt[k + i])});
      put16(b + 10 + 6 * i, 16'h0000);
      put16(b + 12 + 6 * i, da[15:0]);
      for (int j = 0; j < cnt[k + i]; j++)
      begin
        seed = lfsr(seed);
        host_mem_model_inst.mem[da + j] = seed[7:0];
        exp_q.push_back({endf && i == n - 1 && j == cnt[k + i] - 1, seed[7:0]});
      end
    end
  endtask : mk_list
  task automatic wait_st(input logic [15:0] m, input logic [15:0] v);
    for (int i = 0; i < 2000; i++)
    begin
      rd(4'h1, st);
      any_int |= st[2];
      if ((st & m) === v)
        return;
    end
    errors++;
    $display("CHECK FAILED %0t status wait timed out", $time);
    end_of_test;
  endtask : wait_st
  // two frames over three lists; second pass pauses on a cleared valid bit
  task automatic run(input int it);
    got_q.delete();
    exp_q.delete();
    wa_q.delete();
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      cnt[i] = seed[2:0] + (i != 1 && i != 4);
    end
    lat <= it ? 2'h3 : 2'h0;
    mk_list('h100, 'h140, it ? 16'h2000 : 16'ha000, cnt[0] + cnt[1] + cnt[2], 0, 2, 0);
    mk_list('h140, 'h180, 16'h0000, 1, 2, 1, 1);
    mk_list('h180, 'h001, 16'ha800, cnt[3] + cnt[4] + cnt[5], 3, 3, 1);
    launch(24'h000100);
    launch(24'h000180);
    rd(4'h1, st);
    chk(st & 16'h0003, 16'h0003);
    any_int = 1'b0;
    if (it)
    begin
      wait_st(16'h0010, 16'h0010);
      chk(16'(got_q.size()), 16'h0000);
      put16('h104, 16'ha000);
      wr(4'h5, 16'h0081);
    end
    wait_st(16'h0001, 16'h0000);
    chk(st & 16'h0020, 16'h0020);
    chk({15'h0, any_int}, 16'h0001);
    chk(16'(got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i])
      if (i < got_q.size())
        chk_byte(got_q[i], exp_q[i]);
    chk(16'(wa_q.size()), 16'h0002);
    if (wa_q.size() == 2)
    begin
      chk(wa_q[0], 16'h0104);
      chk(wa_q[1], 16'h0184);
    end
    rd(4'h6, st);
    chk(st & 16'h8000, 16'h8000);
  endtask : run
  always @(posedge clock)
  begin
    rdy_s <= lfsr(rdy_s);
    tx_ready <= rdy_s[3] | rdy_s[5];
    if (tx_valid && tx_ready)
      got_q.push_back({tx_last, tx_byte});
    if (mem_wr_req && mem_wr_ack)
      wa_q.push_back(mem_wr_addr[15:0]);
  end
  initial
  begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    launch(24'h000100);
    rd(4'h1, st);
    chk(st & 16'h0003, 16'h0002);
    rd(4'h1, st);
    chk(st & 16'h0002, 16'h0000);
    rd(4'hf, st);
    chk(st, 16'h0000);
    wr(4'h0, 16'h0001);
    launch(24'h000101);
    rd(4'h1, st);
    chk(st & 16'h0003, 16'h0002);
    for (int it = 0; it < 2; it++)
      run(it);
    end_of_test;
  end
endmodule : tb
`default_nettype wire
